// *** design/esc_pkg.sv ***
package esc_pkg;
	// Register map.
	localparam logic [7:0] ESC_EXC_SETUP_ADDR = 8'h09;
	localparam logic [7:0] ESC_EXC_SETUP_RST = 8'h03;
	localparam logic [7:0] ESC_UNMAPPED_READ = 8'h00;

	// Field positions inside the excitation setup register.
	localparam int ESC_CLOCK_HALVE_BIT = 7;
	localparam int ESC_EXCITATION_SCOPE_BIT = 6;
	localparam int ESC_PIN_B_TRUE_BIT = 5;
	localparam int ESC_PIN_B_INV_BIT = 4;
	localparam int ESC_PIN_A_TRUE_BIT = 3;
	localparam int ESC_PIN_A_INV_BIT = 2;
	localparam int ESC_DRIVE_LEVEL_HI_BIT = 1;
	localparam int ESC_DRIVE_LEVEL_LO_BIT = 0;

	// Clock halving factor applied to excitation and modulator rates.
	localparam int ESC_HALVE_FACTOR = 2;

	// Excitation timing: base tick period in ns at clock_halve = 0.
	localparam int ESC_MCLK_PERIOD_NS = 100;
	localparam int ESC_TICK_PERIOD_NS = 800;
	localparam int ESC_TICK_CYCLES = (ESC_TICK_PERIOD_NS + ESC_MCLK_PERIOD_NS - 1)
		/ ESC_MCLK_PERIOD_NS;

	// Pin swing levels in eighths of supply, per level code.
	localparam logic [3:0] ESC_LOW_00 = 4'h3;
	localparam logic [3:0] ESC_HIGH_00 = 4'h5;
	localparam logic [3:0] ESC_LOW_01 = 4'h2;
	localparam logic [3:0] ESC_HIGH_01 = 4'h6;
	localparam logic [3:0] ESC_LOW_10 = 4'h1;
	localparam logic [3:0] ESC_HIGH_10 = 4'h7;
	localparam logic [3:0] ESC_LOW_11 = 4'h0;
	localparam logic [3:0] ESC_HIGH_11 = 4'h8;

	typedef enum logic [1:0] {
		ESC_IDLE,
		ESC_CONVERT
	} esc_state_t;
endpackage : esc_pkg

// *** design/esc_excitation_setup_control.sv ***
// Function
// - Register at pointer 0x09, resets to 0x03
// - Bits: halve, scope, B true/inv, A true/inv, level
// - Halve bit divides excitation and modulator clocks
// - Halve bit doubles every channel's conversion time
// - Bits 5/4 drive pin B true/inverted
// - Bits 3/2 drive pin A true/inverted
// - Conversion times twice as long when halved
`timescale 1ns/100ps
module esc_excitation_setup_control #(
	parameter int TICK_CYCLES = esc_pkg::ESC_TICK_CYCLES,
	parameter int CONV_W = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic conv_start,
	input wire logic conv_is_cap,
	input wire logic [CONV_W-1:0] conv_ticks,
	output logic conv_busy,
	output logic conv_done,
	output logic mod_tick,
	output logic pin_a_drive,
	output logic pin_a_drive_en,
	output logic pin_b_drive,
	output logic pin_b_drive_en,
	output logic [3:0] swing_low_eighths,
	output logic [3:0] swing_high_eighths
);
	import esc_pkg::*;

	localparam int PRE_W = $clog2(TICK_CYCLES * ESC_HALVE_FACTOR + 1);

	// Refuse parameter values that the prescaler and sequencer cannot serve.
	if (TICK_CYCLES < 1 || CONV_W < 1) begin : g_bad_param
		$error("esc_excitation_setup_control: bad parameter");
	end

	logic [7:0] setup_ff, nxt_setup;
	logic [7:0] active_ff, nxt_active;
	esc_state_t state_ff, nxt_state;
	logic [PRE_W-1:0] pre_ff, nxt_pre;
	logic [CONV_W-1:0] cnt_ff, nxt_cnt;
	logic wave_ff, nxt_wave;
	logic done_ff, nxt_done;
	logic tick;
	logic [PRE_W-1:0] pre_limit;
	logic exc_on;
	logic a_en, b_en, a_lvl, b_lvl;
	logic [3:0] low_ff, nxt_low, high_ff, nxt_high;
	logic a_ff, nxt_a, a_en_ff, nxt_a_en, b_ff, nxt_b, b_en_ff, nxt_b_en;

	// Software-visible copy; readback always shows the last write.
	always_comb begin
		nxt_setup = setup_ff;
		if (reg_wr && reg_addr == ESC_EXC_SETUP_ADDR) begin
			nxt_setup = reg_wdata;
		end
	end

	always_comb begin
		reg_rdata = ESC_UNMAPPED_READ;
		if (reg_addr == ESC_EXC_SETUP_ADDR) begin
			reg_rdata = setup_ff;
		end
	end

	// Working copy used by the datapath; it follows the software copy only
	// between conversions, so a write never changes a conversion in flight.
	always_comb begin
		nxt_active = active_ff;
		if (state_ff == ESC_IDLE) begin
			nxt_active = setup_ff;
		end
	end

	// Prescaler: halving doubles the tick period for both rates.
	always_comb begin
		if (active_ff[ESC_CLOCK_HALVE_BIT]) begin
			pre_limit = PRE_W'(TICK_CYCLES * ESC_HALVE_FACTOR - 1);
		end else begin
			pre_limit = PRE_W'(TICK_CYCLES - 1);
		end
		tick = (pre_ff >= pre_limit);
		nxt_pre = tick ? '0 : pre_ff + PRE_W'(1);
	end

	// Conversion sequencer counts modulator ticks, so its length in clock
	// cycles doubles along with the tick period.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		unique case (state_ff)
			ESC_IDLE: begin
				if (conv_start) begin
					nxt_state = ESC_CONVERT;
					nxt_cnt = '0;
				end
			end
			ESC_CONVERT: begin
				if (tick) begin
					if (cnt_ff + CONV_W'(1) >= conv_ticks) begin
						nxt_state = ESC_IDLE;
						nxt_done = 1'b1;
					end else begin
						nxt_cnt = cnt_ff + CONV_W'(1);
					end
				end
			end
		endcase
	end

	// Excitation square wave toggles on each tick while excitation is on.
	always_comb begin
		exc_on = (state_ff == ESC_CONVERT) &&
			(conv_is_cap || active_ff[ESC_EXCITATION_SCOPE_BIT]);
		nxt_wave = wave_ff;
		if (!exc_on) begin
			nxt_wave = 1'b0;
		end else if (tick) begin
			nxt_wave = ~wave_ff;
		end
	end

	// Pin drive; if both enables of a pin are set the true signal wins.
	always_comb begin
		b_en = active_ff[ESC_PIN_B_TRUE_BIT] || active_ff[ESC_PIN_B_INV_BIT];
		b_lvl = active_ff[ESC_PIN_B_TRUE_BIT] ? wave_ff : ~wave_ff;
		a_en = active_ff[ESC_PIN_A_TRUE_BIT] || active_ff[ESC_PIN_A_INV_BIT];
		a_lvl = active_ff[ESC_PIN_A_TRUE_BIT] ? wave_ff : ~wave_ff;
		nxt_a_en = a_en && exc_on;
		nxt_b_en = b_en && exc_on;
		nxt_a = nxt_a_en && a_lvl;
		nxt_b = nxt_b_en && b_lvl;
	end

	// Swing decode in eighths of supply.
	always_comb begin
		unique case ({active_ff[ESC_DRIVE_LEVEL_HI_BIT],
			active_ff[ESC_DRIVE_LEVEL_LO_BIT]})
			2'b00: begin
				nxt_low = ESC_LOW_00;
				nxt_high = ESC_HIGH_00;
			end
			2'b01: begin
				nxt_low = ESC_LOW_01;
				nxt_high = ESC_HIGH_01;
			end
			2'b10: begin
				nxt_low = ESC_LOW_10;
				nxt_high = ESC_HIGH_10;
			end
			2'b11: begin
				nxt_low = ESC_LOW_11;
				nxt_high = ESC_HIGH_11;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			setup_ff <= ESC_EXC_SETUP_RST;
			active_ff <= ESC_EXC_SETUP_RST;
			state_ff <= ESC_IDLE;
			pre_ff <= '0;
			cnt_ff <= '0;
			wave_ff <= 1'b0;
			done_ff <= 1'b0;
			a_ff <= 1'b0;
			a_en_ff <= 1'b0;
			b_ff <= 1'b0;
			b_en_ff <= 1'b0;
			low_ff <= ESC_LOW_11;
			high_ff <= ESC_HIGH_11;
		end else begin
			setup_ff <= nxt_setup;
			active_ff <= nxt_active;
			state_ff <= nxt_state;
			pre_ff <= nxt_pre;
			cnt_ff <= nxt_cnt;
			wave_ff <= nxt_wave;
			done_ff <= nxt_done;
			a_ff <= nxt_a;
			a_en_ff <= nxt_a_en;
			b_ff <= nxt_b;
			b_en_ff <= nxt_b_en;
			low_ff <= nxt_low;
			high_ff <= nxt_high;
		end
	end

	assign conv_busy = (state_ff == ESC_CONVERT);
	assign conv_done = done_ff;
	assign mod_tick = tick;
	assign pin_a_drive = a_ff;
	assign pin_a_drive_en = a_en_ff;
	assign pin_b_drive = b_ff;
	assign pin_b_drive_en = b_en_ff;
	assign swing_low_eighths = low_ff;
	assign swing_high_eighths = high_ff;
endmodule : esc_excitation_setup_control

// *** tb/esc_excitation_setup_control_props.sv ***
`timescale 1ns/100ps
module esc_excitation_setup_control_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic conv_start,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire logic mod_tick,
	input wire logic pin_a_drive_en,
	input wire logic [3:0] swing_low_eighths,
	input wire logic [3:0] swing_high_eighths
);
	import esc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_wr; reg_wr && reg_addr == ESC_EXC_SETUP_ADDR ##1 reg_addr == ESC_EXC_SETUP_ADDR |->
		reg_rdata == $past(reg_wdata); endproperty
	a_wr: assert property (p_wr) else $error("bad readback");
	property p_un; reg_addr != ESC_EXC_SETUP_ADDR |-> reg_rdata == ESC_UNMAPPED_READ; endproperty
	a_un: assert property (p_un) else $error("bad unmapped read");
	property p_go; conv_start && !conv_busy |=> conv_busy; endproperty
	a_go: assert property (p_go) else $error("start lost");
	property p_dn; conv_done |-> !conv_busy && $past(conv_busy); endproperty
	a_dn: assert property (p_dn) else $error("done without busy");
	property p_pl; conv_done |=> !conv_done; endproperty
	a_pl: assert property (p_pl) else $error("done too long");
	property p_en; !conv_busy [*2] |-> !pin_a_drive_en; endproperty
	a_en: assert property (p_en) else $error("pin driven idle");
	property p_sw; swing_low_eighths + swing_high_eighths == 5'd8; endproperty
	a_sw: assert property (p_sw) else $error("swing not centred");
	property p_tk; mod_tick |=> !mod_tick; endproperty
	a_tk: assert property (p_tk) else $error("tick too fast");
endmodule : esc_excitation_setup_control_props
bind esc_excitation_setup_control esc_excitation_setup_control_props
	esc_excitation_setup_control_props_i (.*);

// *** tb/esc_sensor_model.sv ***
`timescale 1ns/100ps
module esc_sensor_model (
	input wire logic mclk,
	input wire logic pin_a_drive,
	input wire logic pin_a_drive_en,
	input wire logic pin_b_drive,
	input wire logic pin_b_drive_en,
	output int edges = 0,
	output int clash = 0
);
	logic a_q = 1'b0;
	// Counts plate A swings and same-phase drive of both plates.
	always @(posedge mclk) begin
		a_q <= pin_a_drive;
		if (pin_a_drive_en && pin_a_drive != a_q) edges <= edges + 1;
		if (pin_a_drive_en && pin_b_drive_en && pin_a_drive == pin_b_drive) clash <= clash + 1;
	end
endmodule : esc_sensor_model

// *** tb/esc_excitation_setup_control_tb.sv ***
`timescale 1ns/100ps
module esc_excitation_setup_control_tb;
	import esc_pkg::*;
	logic mclk = 0, rst = 1, reg_wr = 0, conv_start = 0, conv_is_cap = 0;
	logic [7:0] reg_addr = 8'h09, reg_wdata = 8'h00, reg_rdata;
	logic [15:0] conv_ticks = 16'h0003;
	logic conv_busy, conv_done, mod_tick, pin_a_drive, pin_a_drive_en, pin_b_drive, pin_b_drive_en;
	logic [3:0] swing_low_eighths, swing_high_eighths;
	localparam int TB_TICK = 2;
	int miscompares = 0, comparisons = 0, edges, clash, g, n, m, span;
	logic [7:0] cfg [6] = '{8'h0B, 8'h8B, 8'h0B, 8'h4B, 8'h1B, 8'h2B};
	logic [7:0] lv [4] = '{8'h35, 8'h26, 8'h17, 8'h08};
	logic [5:0] cap = 6'b11_0011;
	esc_excitation_setup_control #(.TICK_CYCLES(TB_TICK)) esc_excitation_setup_control_i (.*);
	esc_sensor_model esc_sensor_model_i (.*);
	initial forever #50 mclk = ~mclk;
	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d);
		@(negedge mclk);
		reg_addr = ESC_EXC_SETUP_ADDR;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge mclk);
		reg_wr = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		#10 chk(reg_rdata, e);
	endtask : rd
	task automatic conv(input logic c);
		int t;
		int lt;
		int ft;
		t = 0;
		lt = 0;
		ft = 0;
		n = edges;
		m = clash;
		@(negedge mclk);
		conv_is_cap = c;
		conv_start = 1;
		do begin
			@(negedge mclk);
			conv_start = 0;
			t++;
			if (mod_tick) begin
				if (lt == 0) begin
					ft = t;
				end
				g = t - lt;
				lt = t;
			end
		end while (conv_done !== 1'b1 && t < 400);
		// Cycles from the first counted tick to the done pulse.
		span = t - ft;
		if (t == 400) begin
			miscompares++;
			results();
		end
	endtask : conv
	initial begin
		repeat (16) @(negedge mclk);
		rst = 0;
		rd(8'h09, ESC_EXC_SETUP_RST);
		rd(8'h0A, 8'h00);
		wr(8'h5A);
		rd(8'h09, 8'h5A);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			wr(8'(i));
			repeat (3) @(negedge mclk);
			chk({swing_low_eighths, swing_high_eighths}, lv[i]);
		end
		$display("level test done");
		for (int i = 0; i < 6; i++) begin
			int f;
			f = cfg[i][7] ? ESC_HALVE_FACTOR : 1;
			wr(cfg[i]);
			conv(cap[i]);
			chk(8'(g), 8'(TB_TICK * f));
			chk(8'(span), 8'((int'(conv_ticks) - 1) * TB_TICK * f + 1));
			chk(8'(edges != n), 8'(cap[i] | cfg[i][6]));
			chk(8'(clash != m), 8'(cfg[i][5] & (cap[i] | cfg[i][6])));
			$display("conversion test %0d done", i);
		end
		chk(8'(clash != 0), 8'h01);
		results();
	end
endmodule : esc_excitation_setup_control_tb
